// file: verilog/lcd_pkg.sv
package lcd_pkg;

  // register byte addresses (one aligned 32-bit word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PHASE_OFS = 8'h04;
  localparam logic [7:0] SEG_BASE = 8'h10;
  localparam logic [7:0] PIX_BASE = 8'h40;
  localparam int WORD_SHIFT = 2;

  // panel geometry
  localparam int NSEG = 33;
  localparam int NCOM = 4;
  localparam int NSEG_REG = 5;
  localparam int PIX_LAST_IDX = 22;
  localparam int PIX_GRP_STRIDE = 6;
  localparam int PIX_GRP_TOP = 4;
  localparam int BYTE_W = 8;

  // clock source encodings
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;

  // postscaler divisors
  localparam int CNT_W = 13;
  localparam int POST_SHORT_DIV = 32;
  localparam int POST_LONG_DIV = 8192;
  localparam int LP_W = 4;

  // bias output encoding
  localparam logic [1:0] BIAS_STATIC = 2'h0;
  localparam logic [1:0] BIAS_HALF = 2'h1;
  localparam logic [1:0] BIAS_THIRD = 2'h2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PHASE_RESET = 8'h00;

  typedef struct packed {
    logic en;
    logic slp_dis;
    logic write_error_flag;
    logic rsv;
    logic [1:0] cs;
    logic [1:0] mux;
  } ctl_t;

  typedef struct packed {
    logic phase_style_select;
    logic bias;
    logic act;
    logic wa;
    logic [LP_W-1:0] lp;
  } ps_t;

  typedef struct packed {
    logic hit;
    logic [1:0] com;
    logic [2:0] grp;
  } pix_sel_t;

  typedef struct packed {
    ctl_t ctl;
    ps_t ps;
    logic [NSEG-1:0] seg;
    logic [NCOM-1:0][NSEG-1:0] pix;
    logic active;
    logic [2:0] rc_sync;
    logic [2:0] t1_sync;
    logic [CNT_W-1:0] post_cnt;
    logic [LP_W-1:0] pre_cnt;
    logic [1:0] com;
    logic phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NCOM-1:0] com_out;
    logic [NSEG-1:0] pix_out;
    logic phase_out;
    logic [1:0] bias_out;
  } state_t;

endpackage

// file: verilog/lcd_ctrl.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - top control bit enables whole driver
// - sleep-disable bit stops driver during sleep
// - pixel write while blocked sets sticky error
// - clock source: RC, timer1 or instruction
// - commons select: static, 1/2, 1/3, 1/4
// - type-B phase flips per frame, A within
// - bias bit picks 1/2 or 1/3 bias with 1/2 or 1/3 commons; 1/4 commons forces 1/3 bias
// - read-only active status mirrors running driver
// - read-only write-allow status for pixel writes
// - frame prescaler divides baseline by k+1
// - segment enable bit makes pin segment driver
// - five enable registers, eight segments each in the first four, segment 32 alone in the fifth
// - pixel bit one is dark, zero clear
// - pixel registers grouped by common, gaps absent
// - segment 32 pixel registers hold bit 0
// - postscaler divides by 32 or 8192
// - commons select sets ring counter length
// - unused control bit 4 reads zero
// - instruction clock uses 8192, others 32
module lcd_ctrl #(
  parameter int unsigned POST_LONG = lcd_pkg::POST_LONG_DIV
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lcd_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RC_CLK_IN,
  input wire logic T1_CLK_IN,
  input wire logic SLEEP,
  output logic [lcd_pkg::NSEG-1:0] SEG_EN,
  output logic [lcd_pkg::NSEG-1:0] PIX_OUT,
  output logic [lcd_pkg::NCOM-1:0] COM_OUT,
  output logic PHASE_OUT,
  output logic [1:0] BIAS_OUT,
  output logic ACTIVE_OUT
);

  if (POST_LONG < lcd_pkg::POST_SHORT_DIV ||
      POST_LONG > (1 << lcd_pkg::CNT_W)) begin : g_bad_post
    $error("POST_LONG out of range for postscaler counter");
  end

  function automatic lcd_pkg::pix_sel_t pix_dec(
    input logic [lcd_pkg::ADDR_W-1:0] a);
    lcd_pkg::pix_sel_t r;
    int idx;
    int g;
    r = '0;
    idx = (int'(a) - int'(lcd_pkg::PIX_BASE)) >>> lcd_pkg::WORD_SHIFT;
    g = idx % lcd_pkg::PIX_GRP_STRIDE;
    // indices 5, 11 and 17 fall on g == 5 and are left unmapped
    if (a >= lcd_pkg::PIX_BASE && a[1:0] == 2'h0 &&
        idx <= lcd_pkg::PIX_LAST_IDX && g <= lcd_pkg::PIX_GRP_TOP) begin
      r.hit = 1'b1;
      r.com = 2'(idx / lcd_pkg::PIX_GRP_STRIDE);
      r.grp = 3'(g);
    end
    return r;
  endfunction

  function automatic logic [7:0] pix_byte(
    input logic [lcd_pkg::NSEG-1:0] row, input logic [2:0] g);
    logic [7:0] b;
    b = 8'h00;
    if (g == 3'(lcd_pkg::PIX_GRP_TOP)) begin
      b[0] = row[lcd_pkg::NSEG-1];
    end else begin
      b = row[g*lcd_pkg::BYTE_W +: lcd_pkg::BYTE_W];
    end
    return b;
  endfunction

  lcd_pkg::state_t s_q;
  lcd_pkg::state_t s_d;

  logic access;
  logic wr_acc;
  logic write_ok;
  logic src_tick;
  logic base_tick;
  logic frame_tick;
  logic [lcd_pkg::CNT_W-1:0] post_max;
  lcd_pkg::pix_sel_t rsel;
  lcd_pkg::pix_sel_t wsel;
  lcd_pkg::ctl_t wctl;
  lcd_pkg::ps_t wps;
  logic [7:0] rbyte;
  logic rhit;
  int unsigned seg_k;

  always_comb begin
    s_d = s_q;
    rbyte = 8'h00;
    rhit = 1'b0;
    seg_k = 0;
    wctl = lcd_pkg::ctl_t'(PWDATA[7:0]);
    wps = lcd_pkg::ps_t'(PWDATA[7:0]);

    // two-flop synchronisers, third flop only for edge detect
    s_d.rc_sync = {s_q.rc_sync[1:0], RC_CLK_IN};
    s_d.t1_sync = {s_q.t1_sync[1:0], T1_CLK_IN};

    // write window closes during the last common of a type-B frame
    write_ok = !(s_q.active && s_q.ps.phase_style_select &&
                 s_q.com == s_q.ctl.mux);

    // clock source and postscaler
    unique case (s_q.ctl.cs)
      lcd_pkg::CS_INSTR: src_tick = 1'b1;
      lcd_pkg::CS_TIMER1: src_tick = s_q.t1_sync[1] && !s_q.t1_sync[2];
      default: src_tick = s_q.rc_sync[1] && !s_q.rc_sync[2];
    endcase
    post_max = (s_q.ctl.cs == lcd_pkg::CS_INSTR) ?
               lcd_pkg::CNT_W'(POST_LONG - 1) :
               lcd_pkg::CNT_W'(lcd_pkg::POST_SHORT_DIV - 1);
    // >= so a lowered end point cannot strand a counter above it
    base_tick = s_q.active && src_tick &&
                s_q.post_cnt >= post_max;
    frame_tick = base_tick && s_q.pre_cnt >= s_q.ps.lp;

    // run state: enabled and not stopped by sleep
    s_d.active = s_q.ctl.en &&
                 !(SLEEP && s_q.ctl.slp_dis);

    if (!s_q.active) begin
      s_d.post_cnt = '0;
      s_d.pre_cnt = '0;
      s_d.com = 2'h0;
      s_d.phase = 1'b0;
    end else begin
      if (src_tick) begin
        s_d.post_cnt = base_tick ? '0 : s_q.post_cnt + 1'b1;
      end
      if (base_tick) begin
        s_d.pre_cnt = frame_tick ? '0 : s_q.pre_cnt + 1'b1;
      end
      if (frame_tick) begin
        if (s_q.ps.phase_style_select) begin
          // type B: one common per tick, phase flips at frame end
          if (s_q.com == s_q.ctl.mux) begin
            s_d.com = 2'h0;
            s_d.phase = !s_q.phase;
          end else begin
            s_d.com = s_q.com + 2'h1;
          end
        end else begin
          // type A: both phases inside each common period
          s_d.phase = !s_q.phase;
          if (s_q.phase) begin
            s_d.com = (s_q.com == s_q.ctl.mux) ? 2'h0 :
                      s_q.com + 2'h1;
          end
        end
      end
      // a smaller commons select must not leave the ring above it
      if (s_q.com > s_q.ctl.mux) begin
        s_d.com = 2'h0;
      end
    end

    // panel-facing outputs
    s_d.com_out = '0;
    s_d.pix_out = '0;
    if (s_q.active) begin
      s_d.com_out[s_q.com] = 1'b1;
      s_d.pix_out = s_q.pix[s_q.com] & s_q.seg;
    end
    s_d.phase_out = s_q.active && s_q.phase;
    if (s_q.ctl.mux == 2'h0) begin
      s_d.bias_out = lcd_pkg::BIAS_STATIC;
    end else if (s_q.ctl.mux != 2'h3 && s_q.ps.bias) begin
      s_d.bias_out = lcd_pkg::BIAS_HALF;
    end else begin
      s_d.bias_out = lcd_pkg::BIAS_THIRD;
    end

    // apb: one wait state, data and error registered for the answer
    access = PSEL && PENABLE;
    wr_acc = access && s_q.pready && PWRITE;
    rsel = pix_dec(PADDR);
    wsel = rsel;
    if (PADDR == lcd_pkg::CTRL_OFS) begin
      rhit = 1'b1;
      rbyte = s_q.ctl;
      rbyte[4] = 1'b0;
    end else if (PADDR == lcd_pkg::PHASE_OFS) begin
      rhit = 1'b1;
      rbyte = {s_q.ps.phase_style_select, s_q.ps.bias, s_q.active, write_ok,
               s_q.ps.lp};
    end else if (PADDR >= lcd_pkg::SEG_BASE && PADDR[1:0] == 2'h0 &&
                 ((PADDR - lcd_pkg::SEG_BASE) >> lcd_pkg::WORD_SHIFT) <
                 lcd_pkg::ADDR_W'(lcd_pkg::NSEG_REG)) begin
      rhit = 1'b1;
      seg_k = 32'((PADDR - lcd_pkg::SEG_BASE) >> lcd_pkg::WORD_SHIFT);
      rbyte = pix_byte(s_q.seg, 3'(seg_k));
    end else if (rsel.hit) begin
      rhit = 1'b1;
      rbyte = pix_byte(s_q.pix[rsel.com], rsel.grp);
    end

    s_d.pready = access && !s_q.pready;
    if (access && !s_q.pready) begin
      s_d.prdata = {24'h000000, rbyte};
      s_d.pslverr = !rhit;
    end else begin
      s_d.prdata = '0;
      s_d.pslverr = 1'b0;
    end

    if (wr_acc && rhit) begin
      if (PADDR == lcd_pkg::CTRL_OFS) begin
        s_d.ctl.en = wctl.en;
        s_d.ctl.slp_dis = wctl.slp_dis;
        s_d.ctl.cs = wctl.cs;
        s_d.ctl.mux = wctl.mux;
        if (!wctl.write_error_flag) begin
          s_d.ctl.write_error_flag = 1'b0;
        end
      end else if (PADDR == lcd_pkg::PHASE_OFS) begin
        s_d.ps.phase_style_select = wps.phase_style_select;
        s_d.ps.bias = wps.bias;
        s_d.ps.lp = wps.lp;
      end else if (wsel.hit) begin
        if (write_ok) begin
          if (wsel.grp == 3'(lcd_pkg::PIX_GRP_TOP)) begin
            s_d.pix[wsel.com][lcd_pkg::NSEG-1] = PWDATA[0];
          end else begin
            s_d.pix[wsel.com][wsel.grp*lcd_pkg::BYTE_W +: lcd_pkg::BYTE_W]
              = PWDATA[7:0];
          end
        end
        // blocked writes change nothing but the error flag
      end else if (seg_k == lcd_pkg::NSEG_REG - 1) begin
        s_d.seg[lcd_pkg::NSEG-1] = PWDATA[0];
      end else begin
        s_d.seg[seg_k*lcd_pkg::BYTE_W +: lcd_pkg::BYTE_W]
          = PWDATA[7:0];
      end
    end
    // set wins over a clear in the same cycle
    if (wr_acc && wsel.hit && !write_ok) begin
      s_d.ctl.write_error_flag = 1'b1;
    end
    s_d.ctl.rsv = 1'b0;
    s_d.ps.act = 1'b0;
    s_d.ps.wa = 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign SEG_EN = s_q.seg;
  assign PIX_OUT = s_q.pix_out;
  assign COM_OUT = s_q.com_out;
  assign PHASE_OUT = s_q.phase_out;
  assign BIAS_OUT = s_q.bias_out;
  assign ACTIVE_OUT = s_q.active;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  write_error_flag_set_a: assert property (
    CE && wr_acc && wsel.hit && !write_ok |=> s_q.ctl.write_error_flag)
    else $error("blocked pixel write did not set error flag");

  blocked_keep_a: assert property (
    CE && wr_acc && wsel.hit && !write_ok |=> $stable(s_q.pix))
    else $error("blocked pixel write changed pixel data");

  active_track_a: assert property (
    CE && !s_q.ctl.en |=> !ACTIVE_OUT ##1 (!CE || COM_OUT == '0))
    else $error("driver ran while disabled");

  sleep_stop_a: assert property (
    CE && SLEEP && s_q.ctl.slp_dis |=> !ACTIVE_OUT)
    else $error("driver kept running in sleep");

  ctrl_rsv_a: assert property (
    PREADY && $past(PADDR) == lcd_pkg::CTRL_OFS |-> PRDATA[4] == 1'b0)
    else $error("control bit 4 read nonzero");

  ring_bound_a: assert property (
    s_q.active && $stable(s_q.ctl.mux) && $past(CE)
    |-> s_q.com <= s_q.ctl.mux)
    else $error("ring counter beyond selected commons");

  com_onehot_a: assert property (
    $onehot0(COM_OUT))
    else $error("more than one common driven");

  seg32_only_a: assert property (
    PREADY && $past(rsel.grp) == 3'h4 && $past(rsel.hit)
    |-> PRDATA[7:1] == 7'h00)
    else $error("segment 32 pixel register upper bits nonzero");

  apb_pulse_a: assert property (
    PREADY |=> !PREADY)
    else $error("ready held more than one cycle");

  apb_wait_a: assert property (
    CE && PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready did not follow the first access cycle");

  bias_static_a: assert property (
    CE && s_q.ctl.mux == 2'h0
    |=> BIAS_OUT == lcd_pkg::BIAS_STATIC)
    else $error("static mode without static bias");

  bias_half_a: assert property (
    CE && s_q.ctl.mux inside {2'h1, 2'h2} && s_q.ps.bias
    |=> BIAS_OUT == lcd_pkg::BIAS_HALF)
    else $error("half bias not selected");

  bias_third_a: assert property (
    CE && s_q.ctl.mux == 2'h3
    |=> BIAS_OUT == lcd_pkg::BIAS_THIRD)
    else $error("four commons without third bias");

  idle_outputs_a: assert property (
    CE && !s_q.active
    |=> COM_OUT == '0 && PIX_OUT == '0 && !PHASE_OUT)
    else $error("panel driven while inactive");

  seg_gate_a: assert property (
    CE
    |=> (PIX_OUT & ~$past(SEG_EN)) == '0)
    else $error("pixel driven on a pin left as plain io");

  err_sticky_a: assert property (
    CE && s_q.ctl.write_error_flag &&
    !(wr_acc && PADDR == lcd_pkg::CTRL_OFS && !wctl.write_error_flag)
    |=> s_q.ctl.write_error_flag)
    else $error("write error flag cleared without software");

  act_status_a: assert property (
    PREADY && $past(CE) && $past(PADDR) == lcd_pkg::PHASE_OFS
    |-> PRDATA[5] == $past(ACTIVE_OUT))
    else $error("active status differs from driver state");

  wa_idle_a: assert property (
    PREADY && $past(CE) && $past(PADDR) == lcd_pkg::PHASE_OFS &&
    !$past(ACTIVE_OUT) |-> PRDATA[4])
    else $error("pixel writes refused while driver idle");

  pix_gap_a: assert property (
    PREADY && $past(CE) && $past(PADDR >= lcd_pkg::PIX_BASE && !rsel.hit)
    |-> PSLVERR)
    else $error("absent pixel register answered without error");

  ring_step_a: assert property (
    CE && frame_tick && s_q.ps.phase_style_select && s_q.com < s_q.ctl.mux
    |=> s_q.com == $past(s_q.com) + 2'h1)
    else $error("ring did not advance one common");

  frame_b_c: cover property (
    s_q.ps.phase_style_select && frame_tick && s_q.com == s_q.ctl.mux && CE);
  write_error_flag_c: cover property (CE && wr_acc && wsel.hit && !write_ok);
  mux4_wrap_c: cover property (
    s_q.ctl.mux == 2'h3 && frame_tick && s_q.com == 2'h3 && CE);
  type_a_c: cover property (!s_q.ps.phase_style_select && frame_tick && s_q.phase);
  ring_clamp_c: cover property (CE && s_q.active && s_q.com > s_q.ctl.mux);

endmodule

// file: dv/lcd_glass.sv
`timescale 1ns/1ns
module lcd_glass (
  input wire logic clk,
  input wire logic clr,
  input wire logic [lcd_pkg::NCOM-1:0] com,
  input wire logic [lcd_pkg::NSEG-1:0] pix,
  output logic [lcd_pkg::NCOM-1:0] seen,
  output logic [lcd_pkg::NCOM-1:0][lcd_pkg::NSEG-1:0] dark,
  output logic bad
);
  // passive glass: only listens, never drives back into the block
  always @(posedge clk) begin
    if (clr) begin
      seen <= '0;
      bad <= 1'b0;
    end else begin
      seen <= seen | com;
      // two commons at once would put a dc level across the cells
      if (!$onehot0(com)) bad <= 1'b1;
      for (int c = 0; c < lcd_pkg::NCOM; c++) begin
        if (com[c]) dark[c] <= pix;
      end
    end
  end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic MCLK, RST_B, PSEL, PENABLE, PWRITE, RC_CLK_IN, T1_CLK_IN, SLEEP;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, PHASE_OUT, ACTIVE_OUT, clr, bad;
  logic [32:0] SEG_EN, PIX_OUT;
  logic [3:0] COM_OUT, seen;
  logic [1:0] BIAS_OUT;
  logic [3:0][32:0] dark;
  logic [9:0] q[$];
  logic [9:0] nt;
  int err_total, tests_run, cnt;

  lcd_ctrl #(.POST_LONG(64)) i_lcd_ctrl (.MCLK(MCLK), .RST_B(RST_B),
    .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RC_CLK_IN(RC_CLK_IN), .T1_CLK_IN(T1_CLK_IN),
    .SLEEP(SLEEP), .SEG_EN(SEG_EN), .PIX_OUT(PIX_OUT), .COM_OUT(COM_OUT),
    .PHASE_OUT(PHASE_OUT), .BIAS_OUT(BIAS_OUT), .ACTIVE_OUT(ACTIVE_OUT));
  lcd_glass i_lcd_glass (.clk(MCLK), .clr(clr), .com(COM_OUT),
    .pix(PIX_OUT), .seen(seen), .dark(dark), .bad(bad));

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  // rc source period 8 clocks, timer1 source period 6 clocks
  always @(posedge MCLK) begin
    if (RST_B !== 1'b1) begin
      cnt <= 0;
      RC_CLK_IN <= 1'b0;
      T1_CLK_IN <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (cnt % 4 == 3) RC_CLK_IN <= ~RC_CLK_IN;
      if (cnt % 3 == 2) T1_CLK_IN <= ~T1_CLK_IN;
    end
  end

  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task timeout;
    err_total++;
    wrap_up();
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, d, e, input logic se);
    int n;
    q.push_back({w, se, e});
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) timeout();
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, d);
    apb(1'b1, a, d, 8'h00, 1'b0);
  endtask

  task rd(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00, e, 1'b0);
  endtask

  // answers are taken in order of issue, one per ready pulse
  always @(posedge MCLK) begin
    if (PREADY === 1'b1) begin
      if (q.size() == 0) chk(40'h1, 40'h0);
      else begin
        nt = q.pop_front();
        chk(40'(PSLVERR), 40'(nt[8]));
        if (!nt[9]) chk(40'(PRDATA), 40'(nt[7:0]));
      end
    end
  end

  function logic [7:0] pa(input int x);
    return lcd_pkg::PIX_BASE + 8'(x << lcd_pkg::WORD_SHIFT);
  endfunction

  function logic [3:0] sig(input bit s);
    return s ? {3'h0, PHASE_OUT} : COM_OUT;
  endfunction

  task waitcom(input logic [3:0] v);
    int n;
    n = 0;
    while (COM_OUT !== v && n < 5000) begin
      @(posedge MCLK);
      n++;
    end
    if (COM_OUT !== v) timeout();
  endtask

  // first interval is discarded, it may straddle a reconfiguration
  task meas(input bit s, input int e);
    logic [3:0] v;
    int n;
    repeat (2) begin
      v = sig(s);
      n = 0;
      while (sig(s) === v && n < 5000) begin
        @(posedge MCLK);
        n++;
      end
    end
    chk(40'(n), 40'(e));
  endtask

  initial begin
    repeat (100000) @(posedge MCLK);
    timeout();
  end

  initial begin
    int c, g, x, t;
    logic [7:0] d;
    logic [39:0] sw;
    logic [3:0][47:0] pw;
    logic [7:0] cfg [8];
    cfg = '{8'h20, 8'h2F, 8'h33, 8'h10, 8'h00, 8'hA0, 8'hE1, 8'h60};
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    SLEEP = 1'b0;
    clr = 1'b1;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h9796));
    repeat (16) @(posedge MCLK);
    RST_B <= 1'b1;
    clr <= 1'b0;
    rd(lcd_pkg::CTRL_OFS, 8'h00);
    rd(lcd_pkg::PHASE_OFS, 8'h10);
    wr(lcd_pkg::CTRL_OFS, 8'h7C);
    rd(lcd_pkg::CTRL_OFS, 8'h4C);
    wr(lcd_pkg::PHASE_OFS, 8'hFF);
    rd(lcd_pkg::PHASE_OFS, 8'hDF);
    apb(1'b0, 8'hFC, 8'h00, 8'h00, 1'b1);
    $display("test control finished");
    for (c = 0; c < 5; c++) begin
      d = 8'($urandom);
      sw[8*c +: 8] = d;
      wr(lcd_pkg::SEG_BASE + 8'(c << 2), d);
    end
    for (c = 0; c < 5; c++) begin
      d = (c == 4) ? {7'h0, sw[32]} : sw[8*c +: 8];
      rd(lcd_pkg::SEG_BASE + 8'(c << 2), d);
    end
    chk(40'(SEG_EN), 40'(sw[32:0]));
    for (x = 0; x < 23; x++) begin
      d = 8'($urandom);
      pw[x / 6][8*(x % 6) +: 8] = d;
      if (x % 6 != 5) wr(pa(x), d);
    end
    for (x = 0; x < 23; x++) begin
      c = x / 6;
      g = x % 6;
      d = (g == 4) ? {7'h0, pw[c][32]} : pw[c][8*g +: 8];
      if (g == 5) apb(1'b0, pa(x), 8'h00, 8'h00, 1'b1);
      else rd(pa(x), d);
    end
    $display("test registers finished");
    for (c = 0; c < 4; c++) begin
      for (g = 0; g < 2; g++) begin
        wr(lcd_pkg::PHASE_OFS,
           {1'b1, 1'(g) & 1'(c == 1 || c == 2), 6'h00});
        wr(lcd_pkg::CTRL_OFS, {6'h20, 2'(c)});
        clr <= 1'b1;
        @(posedge MCLK);
        clr <= 1'b0;
        repeat (300) @(posedge MCLK);
        chk(40'(seen), 40'((1 << (c + 1)) - 1));
        t = (c == 0) ? 0 : (c == 3 || g == 0) ? 2 : 1;
        chk(40'(BIAS_OUT), 40'(t));
        chk(40'(ACTIVE_OUT), 40'h1);
      end
    end
    for (c = 0; c < 4; c++) begin
      chk(40'(dark[c]), 40'(pw[c][32:0] & sw[32:0]));
    end
    $display("test multiplex finished");
    waitcom(4'h8);
    rd(lcd_pkg::PHASE_OFS, 8'hA0);
    wr(pa(0), ~pw[0][7:0]);
    rd(pa(0), pw[0][7:0]);
    rd(lcd_pkg::CTRL_OFS, 8'hA3);
    wr(lcd_pkg::CTRL_OFS, 8'h83);
    rd(lcd_pkg::CTRL_OFS, 8'h83);
    waitcom(4'h1);
    rd(lcd_pkg::PHASE_OFS, 8'hB0);
    $display("test write allow finished");
    for (x = 0; x < 8; x++) begin
      d = cfg[x];
      wr(lcd_pkg::CTRL_OFS, {4'h8, d[7:6], 2'h1});
      wr(lcd_pkg::PHASE_OFS, {d[5], 3'h0, d[3:0]});
      t = (d[7:6] == 2'h0) ? 64 : d[7] ? 256 : 192;
      t = t * (int'(d[3:0]) + 1) * ((d[4] ^ d[5]) ? 1 : 2);
      meas(d[4], t);
    end
    $display("test timing finished");
    wr(lcd_pkg::CTRL_OFS, 8'hC1);
    SLEEP <= 1'b1;
    repeat (3) @(posedge MCLK);
    chk(40'(ACTIVE_OUT), 40'h0);
    SLEEP <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk(40'(ACTIVE_OUT), 40'h1);
    wr(lcd_pkg::CTRL_OFS, 8'h81);
    SLEEP <= 1'b1;
    repeat (3) @(posedge MCLK);
    chk(40'(ACTIVE_OUT), 40'h1);
    SLEEP <= 1'b0;
    wr(lcd_pkg::CTRL_OFS, 8'h01);
    repeat (3) @(posedge MCLK);
    chk(40'({ACTIVE_OUT, COM_OUT, PHASE_OUT}), 40'h0);
    rd(lcd_pkg::PHASE_OFS, 8'h90);
    chk(40'(bad), 40'h0);
    $display("test sleep and disable finished");
    wrap_up();
  end
endmodule
